/* File: logic/pin_dir_cfg.svh */
`ifndef PIN_DIR_CFG_SVH
`define PIN_DIR_CFG_SVH
`define PINS_PER_GROUP 32
`define GROUP_COUNT 2
`define GROUP_STRIDE 12'h080
`define GROUP_OFFSET_MASK 12'h07F
`define OFF_WAY 7'h00
`define OFF_MAKE_INPUT 7'h04
`define OFF_MAKE_DRIVE 7'h08
`define OFF_FLIP_WAY 7'h0C
`define OFF_LEVEL 7'h10
`define OFF_LEVEL_LOW 7'h14
`define OFF_LEVEL_HIGH 7'h18
`define OFF_LEVEL_FLIP 7'h1C
`define OFF_PULL_EN 7'h40
`define OFF_GUARD 7'h7C
`define REG_RESET 32'h00000000
`endif

/* File: logic/pin_dir_pkg.sv */
package pin_dir_pkg;
  typedef enum logic [2:0] {
    OP_NONE = 3'b000,
    OP_WRITE = 3'b001,
    OP_SET = 3'b010,
    OP_CLEAR = 3'b011,
    OP_FLIP = 3'b100
  } mask_op_t;
  typedef struct packed {
    logic [31:0] way;
    logic [31:0] level;
    logic [31:0] pull_en;
  } group_regs_t;
  typedef struct packed {
    logic [31:0] drive_en;
    logic [31:0] drive_level;
    logic [31:0] pull_en;
    logic [31:0] pull_up;
  } pad_ctrl_t;
endpackage

/* File: logic/mask_apply.sv */
`timescale 1ns/10ps
// Next value of one 32-bit register under a plain or masked write (no storage here)
module mask_apply (
  input wire pin_dir_pkg::mask_op_t op_in,
  input wire logic [31:0] cur_in,
  input wire logic [31:0] wdata_in,
  output logic [31:0] next_out
);
  always_comb begin
    unique case (op_in)
      pin_dir_pkg::OP_NONE: next_out = cur_in;
      pin_dir_pkg::OP_WRITE: next_out = wdata_in;
      pin_dir_pkg::OP_SET: next_out = cur_in | wdata_in;
      pin_dir_pkg::OP_CLEAR: next_out = cur_in & ~wdata_in;
      pin_dir_pkg::OP_FLIP: next_out = cur_in ^ wdata_in;
      default: next_out = cur_in;
    endcase
  end
endmodule // mask_apply

/* File: logic/pin_dir_top.sv */
`timescale 1ns/10ps
`include "pin_dir_cfg.svh"
module pin_dir_top (
  input wire logic clk_sys_in,
  input wire logic rst_n_in,
  input wire logic clk_en_in,
  input wire logic psel_in,
  input wire logic penable_in,
  input wire logic pwrite_in,
  input wire logic [11:0] paddr_in,
  input wire logic [31:0] pwdata_in,
  output logic [31:0] prdata_out,
  output logic pready_out,
  output logic pslverr_out,
  output logic [31:0] pad_oe_out [`GROUP_COUNT],
  output logic [31:0] pad_o_out [`GROUP_COUNT],
  output logic [31:0] pad_pull_en_out [`GROUP_COUNT],
  output logic [31:0] pad_pull_up_out [`GROUP_COUNT],
  output logic guard_locked_out
);

  ////////////////////////////////////////////////////////////////////////
  typedef struct packed {
    pin_dir_pkg::group_regs_t [`GROUP_COUNT-1:0] grp;
    logic guard;
    logic [31:0] rdata;
  } state_t;

  state_t state_reg;
  state_t state_next;

  function automatic logic known_offset(input logic [6:0] off);
    known_offset = (off[1:0] == 2'b00) &&
      ((off <= `OFF_LEVEL_FLIP) || (off == `OFF_PULL_EN) ||
       (off == `OFF_GUARD));
  endfunction

  function automatic pin_dir_pkg::mask_op_t op_for(
      input logic [6:0] off, input logic [6:0] base);
    if (off == base)
      op_for = pin_dir_pkg::OP_WRITE;
    else if (off == base + 7'h04)
      op_for = pin_dir_pkg::OP_CLEAR;
    else if (off == base + 7'h08)
      op_for = pin_dir_pkg::OP_SET;
    else if (off == base + 7'h0C)
      op_for = pin_dir_pkg::OP_FLIP;
    else
      op_for = pin_dir_pkg::OP_NONE;
  endfunction

  ////////////////////////////////////////////////////////////////////////
  logic access_w;
  logic [6:0] off_w;
  logic [4:0] grp_sel_w;
  logic grp_ok_w;
  logic map_ok_w;
  logic wr_w;
  logic rd_w;
  logic [31:0] way_next_w [`GROUP_COUNT];
  logic [31:0] level_next_w [`GROUP_COUNT];
  pin_dir_pkg::mask_op_t way_op_w [`GROUP_COUNT];
  pin_dir_pkg::mask_op_t level_op_w [`GROUP_COUNT];

  // Zero-wait slave: every access phase completes at once
  assign access_w = psel_in & penable_in & clk_en_in;
  assign off_w = paddr_in[6:0];
  assign grp_sel_w = paddr_in[11:7];
  assign grp_ok_w = grp_sel_w < 5'(`GROUP_COUNT);
  assign map_ok_w = grp_ok_w && known_offset(off_w) &&
    !(off_w == `OFF_GUARD && grp_sel_w != 5'h00);
  assign wr_w = access_w & pwrite_in & map_ok_w;
  // Read word is latched in the setup cycle so it stands in the access phase
  assign rd_w = psel_in & ~penable_in & clk_en_in & ~pwrite_in & map_ok_w;
  assign pready_out = 1'b1;
  assign pslverr_out = psel_in & penable_in & ~map_ok_w;
  assign prdata_out = state_reg.rdata;
  assign guard_locked_out = state_reg.guard;

  for (genvar g = 0; g < `GROUP_COUNT; g++) begin : g_grp
    logic hit;
    // Locked guard blocks every alias, not just the base register
    assign hit = wr_w && grp_sel_w == 5'(g) && !state_reg.guard;
    assign way_op_w[g] = hit ? op_for(off_w, `OFF_WAY)
                             : pin_dir_pkg::OP_NONE;
    assign level_op_w[g] = hit ? op_for(off_w, `OFF_LEVEL)
                               : pin_dir_pkg::OP_NONE;
    mask_apply u_way (
      .op_in(way_op_w[g]),
      .cur_in(state_reg.grp[g].way),
      .wdata_in(pwdata_in),
      .next_out(way_next_w[g])
    );
    mask_apply u_level (
      .op_in(level_op_w[g]),
      .cur_in(state_reg.grp[g].level),
      .wdata_in(pwdata_in),
      .next_out(level_next_w[g])
    );
    // Pads only see register state, so no glitch from bus decode
    assign pad_oe_out[g] = state_reg.grp[g].way;
    assign pad_o_out[g] = state_reg.grp[g].level;
    assign pad_pull_en_out[g] =
      ~state_reg.grp[g].way & state_reg.grp[g].pull_en;
    assign pad_pull_up_out[g] =
      ~state_reg.grp[g].way & state_reg.grp[g].pull_en &
      state_reg.grp[g].level;
  end

  ////////////////////////////////////////////////////////////////////////
  always_comb begin
    logic [31:0] rsel;
    rsel = 32'h00000000;
    state_next = state_reg;
    for (int g = 0; g < `GROUP_COUNT; g++) begin
      state_next.grp[g].way = way_next_w[g];
      state_next.grp[g].level = level_next_w[g];
      if (wr_w && grp_sel_w == 5'(g) && !state_reg.guard &&
          off_w == `OFF_PULL_EN)
        state_next.grp[g].pull_en = pwdata_in;
    end
    // Guard itself stays writable so software can unlock
    if (wr_w && off_w == `OFF_GUARD)
      state_next.guard = pwdata_in[0];
    if (rd_w) begin
      if (off_w == `OFF_GUARD)
        rsel = {31'h00000000, state_reg.guard};
      else if (off_w == `OFF_PULL_EN)
        rsel = state_reg.grp[grp_sel_w[0]].pull_en;
      else if (off_w < `OFF_LEVEL)
        rsel = state_reg.grp[grp_sel_w[0]].way;
      else
        rsel = state_reg.grp[grp_sel_w[0]].level;
      state_next.rdata = rsel;
    end
  end

  always_ff @(posedge clk_sys_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      state_reg <= '0;
    end else if (clk_en_in) begin
      state_reg <= state_next;
    end
  end

  // Read data is a flop loaded at the setup edge, so it is valid
  // throughout the access phase and pready can stay high.

  ////////////////////////////////////////////////////////////////////////
  property p_wr(logic [6:0] off, logic [31:0] expv);
    @(posedge clk_sys_in) disable iff (!rst_n_in)
    (wr_w && !state_reg.guard && grp_sel_w == 5'h00 && off_w == off)
      |=> state_reg.grp[0].way == $past(expv);
  endproperty

  clear_way_a: assert property (p_wr(`OFF_MAKE_INPUT,
    state_reg.grp[0].way & ~pwdata_in))
    else $error("make-input write wrong");
  set_way_a: assert property (p_wr(`OFF_MAKE_DRIVE,
    state_reg.grp[0].way | pwdata_in))
    else $error("make-drive write wrong");
  flip_way_a: assert property (p_wr(`OFF_FLIP_WAY,
    state_reg.grp[0].way ^ pwdata_in))
    else $error("flip write wrong");
  zero_mask_a: assert property (@(posedge clk_sys_in)
    disable iff (!rst_n_in)
    (wr_w && off_w == `OFF_MAKE_DRIVE && grp_sel_w == 5'h00 &&
     pwdata_in == 32'h00000000) |=> $stable(state_reg.grp[0].way))
    else $error("zero mask changed direction");
  shared_read_a: assert property (@(posedge clk_sys_in)
    disable iff (!rst_n_in)
    (rd_w && grp_sel_w == 5'h00 && off_w == `OFF_FLIP_WAY)
      |=> prdata_out == $past(state_reg.grp[0].way))
    else $error("alias read differs");
  drive_level_a: assert property (@(posedge clk_sys_in)
    disable iff (!rst_n_in)
    (wr_w && !state_reg.guard && grp_sel_w == 5'h00 &&
     off_w == `OFF_LEVEL_HIGH)
      |=> (pad_o_out[0] & $past(pwdata_in)) ==
        $past(pwdata_in))
    else $error("level set missed pad");
  pull_way_a: assert property (@(posedge clk_sys_in)
    disable iff (!rst_n_in)
    (pad_pull_up_out[0] & (state_reg.grp[0].way |
     ~state_reg.grp[0].pull_en)) == 32'h00000000)
    else $error("pull on driven pin");
  guard_block_a: assert property (@(posedge clk_sys_in)
    disable iff (!rst_n_in)
    (state_reg.guard && clk_en_in) |=>
      $stable(state_reg.grp[1].way) && $stable(state_reg.grp[1].level))
    else $error("write while locked");
  stride_a: assert property (@(posedge clk_sys_in)
    disable iff (!rst_n_in)
    (wr_w && grp_sel_w == 5'h01) |=> $stable(state_reg.grp[0].way))
    else $error("group crosstalk");

  set_cover_c: cover property (@(posedge clk_sys_in)
    wr_w && off_w == `OFF_MAKE_DRIVE);
  flip_cover_c: cover property (@(posedge clk_sys_in)
    wr_w && off_w == `OFF_LEVEL_FLIP ##1 rd_w);
  lock_cover_c: cover property (@(posedge clk_sys_in)
    state_reg.guard && wr_w);
endmodule // pin_dir_top

/* File: verif/pad_model.sv */
`timescale 1ns/10ps
// Pins and outside circuits of one group; a floating pin wanders every
// cycle so no check can lean on a stale level
module pad_model (
  input wire logic clk_in,
  input wire logic [31:0] oe_in,
  input wire logic [31:0] lvl_in,
  input wire logic [31:0] pen_in,
  input wire logic [31:0] pup_in,
  output logic [31:0] pin_out
);
  logic [31:0] float_reg = 32'h5A5A_5A5A;
  always @(posedge clk_in) float_reg <= ~float_reg;
  assign pin_out = (oe_in & lvl_in) |
    (~oe_in & pen_in & pup_in) |
    (~oe_in & ~pen_in & float_reg);
endmodule // pad_model

/* File: verif/pin_dir_top_tb.sv */
`timescale 1ns/10ps
`include "pin_dir_cfg.svh"
module pin_dir_top_tb;
  logic clk = 1'b0, rst_n = 1'b0, psel = 1'b0, pen_r = 1'b0, pwr = 1'b0;
  logic [11:0] paddr = 12'h000;
  logic [31:0] pwdata = 32'h0000_0000, prdata, rd, pin;
  logic pready, perr, locked, err;
  logic ce = 1'b1;
  logic [31:0] oe [`GROUP_COUNT];
  logic [31:0] lv [`GROUP_COUNT];
  logic [31:0] pe [`GROUP_COUNT];
  logic [31:0] pu [`GROUP_COUNT];
  int num_errors = 0;
  int cmp_count = 0;
  always #20 clk = ~clk;
  pin_dir_top i_pin_dir_top (.clk_sys_in(clk), .rst_n_in(rst_n),
    .clk_en_in(ce), .psel_in(psel), .penable_in(pen_r), .pwrite_in(pwr),
    .paddr_in(paddr), .pwdata_in(pwdata), .prdata_out(prdata),
    .pready_out(pready), .pslverr_out(perr), .pad_oe_out(oe),
    .pad_o_out(lv), .pad_pull_en_out(pe), .pad_pull_up_out(pu),
    .guard_locked_out(locked));
  pad_model i_pad_model (.clk_in(clk), .oe_in(oe[0]), .lvl_in(lv[0]),
    .pen_in(pe[0]), .pup_in(pu[0]), .pin_out(pin));
  ////////////////////////////////////////////////////////////////////////
  task give_verdict;
    if (num_errors == 0 && cmp_count > 0) $display("All checks passed");
    else $display("Checks failed");
    $finish;
  endtask
  task chk(input logic [31:0] got, input logic [31:0] exp);
    cmp_count++;
    if (got !== exp) begin
      num_errors++;
      $display("[ERR] %0t got %h exp %h", $time, got, exp);
    end
  endtask
  task apb(input logic w, input logic [11:0] a, input logic [31:0] d);
    int n;
    @(posedge clk);
    psel <= 1'b1;
    pwr <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge clk);
    pen_r <= 1'b1;
    n = 0;
    do begin
      @(posedge clk);
      n++;
    end while (pready !== 1'b1 && n < 16);
    if (n >= 16) begin
      num_errors++;
      give_verdict();
    end
    err = perr;
    rd = prdata;
    psel <= 1'b0;
    pen_r <= 1'b0;
    // Let the access edge settle into registers and pads
    @(posedge clk);
  endtask
  task wr(input logic [11:0] a, input logic [31:0] d);
    apb(1'b1, a, d);
  endtask
  task rchk(input logic [11:0] a, input logic [31:0] exp);
    apb(1'b0, a, 32'h0000_0000);
    chk(rd, exp);
  endtask
  ////////////////////////////////////////////////////////////////////////
  task t_reset;
    for (int a = 0; a < 32; a += 4) rchk(a[11:0], 32'h0000_0000);
    chk(oe[0] | lv[0], 32'h0000_0000);
  endtask
  task t_dir;
    wr(12'h008, 32'h0000_00FF);
    chk(oe[0], 32'h0000_00FF);
    rchk(12'h004, 32'h0000_00FF);
    wr(12'h004, 32'h0000_000F);
    rchk(12'h00C, 32'h0000_00F0);
    wr(12'h00C, 32'h0000_0F0F);
    rchk(12'h000, 32'h0000_0FFF);
    for (int a = 4; a < 16; a += 4) begin
      wr(a[11:0], 32'h0000_0000);
      chk(oe[0], 32'h0000_0FFF);
    end
  endtask
  task t_level;
    wr(12'h010, 32'h0000_00A5);
    wr(12'h018, 32'h0000_0100);
    wr(12'h014, 32'h0000_0005);
    wr(12'h01C, 32'h0000_0003);
    rchk(12'h014, 32'h0000_01A3);
    chk(pin & 32'h0000_0FFF, 32'h0000_01A3);
  endtask
  task t_pull;
    wr(12'h040, 32'h0000_F00F);
    chk(pe[0], 32'h0000_F000);
    chk(pin & 32'h0000_F000, 32'h0000_0000);
    wr(12'h018, 32'h0000_5000);
    chk(pu[0], 32'h0000_5000);
    chk(pin & 32'h0000_F000, 32'h0000_5000);
  endtask
  task t_group;
    wr(12'h088, 32'h8000_0001);
    chk(oe[1], 32'h8000_0001);
    chk(oe[0], 32'h0000_0FFF);
    wr(12'h100, 32'hFFFF_FFFF);
    chk({31'h0, err}, 32'h0000_0001);
    wr(12'h020, 32'hFFFF_FFFF);
    chk({31'h0, err}, 32'h0000_0001);
  endtask
  task t_guard;
    wr(12'h07C, 32'h0000_0001);
    chk({31'h0, locked}, 32'h0000_0001);
    wr(12'h008, 32'hFFFF_FFFF);
    wr(12'h010, 32'h0000_0000);
    chk(oe[0], 32'h0000_0FFF);
    chk(lv[0], 32'h0000_51A3);
    wr(12'h07C, 32'h0000_0000);
    wr(12'h00C, 32'h0000_0FFF);
    chk(oe[0], 32'h0000_0000);
  endtask
  // Clock enable low: the bus completes but no state may move
  task t_freeze;
    @(posedge clk);
    ce <= 1'b0;
    wr(12'h00C, 32'hFFFF_FFFF);
    chk(oe[0], 32'h0000_0000);
    ce <= 1'b1;
    wr(12'h00C, 32'h0000_0001);
    chk(oe[0], 32'h0000_0001);
  endtask
  initial begin
    repeat (8) @(posedge clk);
    rst_n <= 1'b1;
    t_reset();
    t_dir();
    t_level();
    t_pull();
    t_group();
    t_guard();
    t_freeze();
    give_verdict();
  end
endmodule // pin_dir_top_tb
